// file: logic/clpwm_top.sv
// Eight-channel cubic LED dimmer with switch and serial register access.
// Assumes switches and bus pins are asynchronous; bus pins are open drain
// with pull-ups outside.
`timescale 1ns/1ps
module clpwm_top #(
    parameter int unsigned PWM_PERIOD = clpwm_pkg::PWM_CYCLES
) (
    // Clock and reset
    input wire logic sysClk,
    input wire logic rst,
    // Switch inputs
    input wire logic [7:0] dedicatedInputPins,
    // Bus clock pin (bidir pin two)
    input wire logic sclIn,
    output clpwm_pkg::clpwm_pad_t sclPad,
    // Bus data pin (bidir pin one)
    input wire logic sdaIn,
    output clpwm_pkg::clpwm_pad_t sdaPad,
    // LED outputs
    output logic [7:0] ledPwm,
    // Mode indicator, high once the bus owns the registers
    output logic busMode
);
    // Cube of the setting scaled into the 16-bit duty range
    function automatic logic [15:0] cubeDuty(input logic [7:0] v);
        logic [23:0] c;
        c = 24'(v) * 24'(v) * 24'(v);
        return c[23:8];
    endfunction : cubeDuty

    // Switch pattern for one channel
    function automatic logic [7:0] swPattern(input logic [7:0] sw, input int n);
        logic [7:0] step;
        step = 8'(n) * clpwm_pkg::SW_STEP;
        if (n == 0) begin
            return sw;
        end
        return (sw == 8'h00) ? 8'h00 : (sw ^ step);
    endfunction : swPattern

    // Synchronisers
    logic [7:0] swMeta_q;
    logic [7:0] swSync_q;
    logic sclMeta_q;
    logic sclSync_q;
    logic sclPrev_q;
    logic sdaMeta_q;
    logic sdaSync_q;
    logic sdaPrev_q;
    // Channel registers and mode
    logic [7:0] chanValue_q [clpwm_pkg::CHANNELS];
    logic busMode_q;
    // PWM state
    logic [15:0] pwmCnt_q;
    logic [15:0] dutyLat_q [clpwm_pkg::CHANNELS];
    logic [7:0] ledPwm_q;
    // Serial target state
    clpwm_pkg::clpwm_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bitCnt_q;
    logic [7:0] ptr_q;
    logic firstByte_q;
    logic masterNack_q;
    logic [7:0] txByte_q;
    logic sdaDrvN_q;
    logic sclDrvN_q;
    // Bus events
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic wrStb;
    logic pwmWrap;

    // Edge and condition decode on synchronised bus pins
    always_comb begin
        sclRise = sclSync_q & ~sclPrev_q;
        sclFall = ~sclSync_q & sclPrev_q;
        startSeen = sclSync_q & sclPrev_q & ~sdaSync_q & sdaPrev_q;
        stopSeen = sclSync_q & sclPrev_q & sdaSync_q & ~sdaPrev_q;
        wrStb = (state_q == clpwm_pkg::ST_RX) && sclFall
            && (bitCnt_q == clpwm_pkg::BYTE_BITS) && !firstByte_q;
        pwmWrap = (pwmCnt_q == 16'(PWM_PERIOD - 1));
    end

    // Two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            swMeta_q <= 8'h00;
            swSync_q <= 8'h00;
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            swMeta_q <= dedicatedInputPins;
            swSync_q <= swMeta_q;
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    // Mode flag: sticky until reset
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            busMode_q <= 1'b0;
        end else if (wrStb) begin
            busMode_q <= 1'b1;
        end
    end

    // Channel registers: switches until the bus takes over
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            for (int n = 0; n < clpwm_pkg::CHANNELS; n++) begin
                chanValue_q[n] <= clpwm_pkg::CHAN_RESET;
            end
        end else if (wrStb) begin
            // Pointers past the last channel store nothing
            if (ptr_q <= clpwm_pkg::REG_CHAN_LAST) begin
                chanValue_q[ptr_q[2:0]] <= shift_q;
            end
        end else if (!busMode_q) begin
            for (int n = 0; n < clpwm_pkg::CHANNELS; n++) begin
                chanValue_q[n] <= swPattern(swSync_q, n);
            end
        end
    end

    // Period counter; 65536 cycles at the nominal clock is 500 Hz
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            pwmCnt_q <= 16'h0000;
        end else if (pwmWrap) begin
            pwmCnt_q <= 16'h0000;
        end else begin
            pwmCnt_q <= pwmCnt_q + 16'h0001;
        end
    end

    // Duty latched once a period so a write never makes a runt pulse
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            for (int n = 0; n < clpwm_pkg::CHANNELS; n++) begin
                dutyLat_q[n] <= 16'h0000;
            end
        end else if (pwmWrap) begin
            for (int n = 0; n < clpwm_pkg::CHANNELS; n++) begin
                dutyLat_q[n] <= cubeDuty(chanValue_q[n]);
            end
        end
    end

    // Compare stage; zero duty never turns on
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            ledPwm_q <= 8'h00;
        end else begin
            for (int n = 0; n < clpwm_pkg::CHANNELS; n++) begin
                ledPwm_q[n] <= (pwmCnt_q < dutyLat_q[n]);
            end
        end
    end

    // Serial target sequencer; start and stop override every state
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            state_q <= clpwm_pkg::ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= clpwm_pkg::REG_CHAN_FIRST;
            firstByte_q <= 1'b0;
            masterNack_q <= 1'b0;
            txByte_q <= 8'h00;
            sdaDrvN_q <= 1'b1;
        end else if (startSeen) begin
            // Repeated start keeps the pointer
            state_q <= clpwm_pkg::ST_ADDR;
            bitCnt_q <= 4'h0;
            sdaDrvN_q <= 1'b1;
        end else if (stopSeen) begin
            state_q <= clpwm_pkg::ST_IDLE;
            sdaDrvN_q <= 1'b1;
        end else begin
            case (state_q)
                clpwm_pkg::ST_ADDR, clpwm_pkg::ST_RX: begin
                    // Sample on rise, decide on the fall after bit eight
                    if (sclRise) begin
                        shift_q <= {shift_q[6:0], sdaSync_q};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == clpwm_pkg::BYTE_BITS) begin
                        bitCnt_q <= 4'h0;
                        if (state_q == clpwm_pkg::ST_RX) begin
                            sdaDrvN_q <= 1'b0;
                            state_q <= clpwm_pkg::ST_DACK;
                            firstByte_q <= 1'b0;
                            if (firstByte_q) begin
                                ptr_q <= shift_q;
                            end else begin
                                ptr_q <= ptr_q + 8'h01;
                            end
                        end else if (shift_q[7:1] == clpwm_pkg::TARGET_ADDR) begin
                            sdaDrvN_q <= 1'b0;
                            state_q <= clpwm_pkg::ST_AACK;
                        end else begin
                            // Other targets: stay off the bus
                            state_q <= clpwm_pkg::ST_IDLE;
                        end
                    end
                end
                clpwm_pkg::ST_AACK: begin
                    if (sclFall) begin
                        if (shift_q[0]) begin
                            // Read: first byte out immediately
                            txByte_q <= {chanValue_q[ptr_q[2:0]][6:0], 1'b0};
                            sdaDrvN_q <= chanValue_q[ptr_q[2:0]][7];
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= clpwm_pkg::ST_TX;
                        end else begin
                            sdaDrvN_q <= 1'b1;
                            firstByte_q <= 1'b1;
                            state_q <= clpwm_pkg::ST_RX;
                        end
                    end
                end
                clpwm_pkg::ST_DACK: begin
                    if (sclFall) begin
                        sdaDrvN_q <= 1'b1;
                        state_q <= clpwm_pkg::ST_RX;
                    end
                end
                clpwm_pkg::ST_TX: begin
                    if (sclRise) begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == clpwm_pkg::BYTE_BITS) begin
                            bitCnt_q <= 4'h0;
                            sdaDrvN_q <= 1'b1;
                            state_q <= clpwm_pkg::ST_MACK;
                        end else begin
                            sdaDrvN_q <= txByte_q[7];
                            txByte_q <= {txByte_q[6:0], 1'b0};
                        end
                    end
                end
                clpwm_pkg::ST_MACK: begin
                    // Controller acknowledges to ask for another byte
                    if (sclRise) begin
                        masterNack_q <= sdaSync_q;
                    end else if (sclFall) begin
                        if (masterNack_q) begin
                            state_q <= clpwm_pkg::ST_IDLE;
                        end else begin
                            txByte_q <= {chanValue_q[ptr_q[2:0]][6:0], 1'b0};
                            sdaDrvN_q <= chanValue_q[ptr_q[2:0]][7];
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= clpwm_pkg::ST_TX;
                        end
                    end
                end
                clpwm_pkg::ST_IDLE: begin
                    sdaDrvN_q <= 1'b1;
                end
                default: begin
                    state_q <= clpwm_pkg::ST_IDLE;
                    sdaDrvN_q <= 1'b1;
                end
            endcase
        end
    end

    // Clock pin is never stretched; kept as a flop for a clean output
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            sclDrvN_q <= 1'b1;
        end else begin
            sclDrvN_q <= 1'b1;
        end
    end

    // Output assignments, straight from flops except the pad out levels, which are tied low
    always_comb begin
        ledPwm = ledPwm_q;
        busMode = busMode_q;
        sdaPad.out = 1'b0;
        sdaPad.drvN = sdaDrvN_q;
        sclPad.out = 1'b0;
        sclPad.drvN = sclDrvN_q;
    end

    // Checks
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (rst);

    a_sw_chan_zero: assert property (
        !$past(busMode_q) && !$past(wrStb) |-> chanValue_q[0] == $past(swSync_q))
        else $error("channel 0 did not follow switches");
    a_sw_all_zero: assert property (
        !busMode_q && swSync_q == 8'h00 && !wrStb |=> chanValue_q[5] == 8'h00)
        else $error("channel 5 not zero for zero switches");
    a_sw_xor_pat: assert property (
        !busMode_q && swSync_q != 8'h00 && !wrStb
        |=> chanValue_q[3] == ($past(swSync_q) ^ 8'h30))
        else $error("channel 3 pattern wrong");
    a_mode_sticky: assert property (
        busMode_q |=> busMode_q && ($stable(chanValue_q[2]) || $past(wrStb)))
        else $error("bus mode lost or switches leaked");
    a_mode_entry: assert property (
        !busMode_q && !wrStb |=> !busMode_q)
        else $error("bus mode without a write");
    a_period_wrap: assert property (
        pwmWrap |=> pwmCnt_q == 16'h0000 ##1 pwmCnt_q == 16'h0001)
        else $error("period counter wrap wrong");
    // Cube written out here, not through the datapath function
    a_cube_duty: assert property (
        pwmWrap |=> 24'(dutyLat_q[1]) == ((24'($past(chanValue_q[1]))
            * 24'($past(chanValue_q[1])) * 24'($past(chanValue_q[1]))) >> 8))
        else $error("duty not cubic");
    a_zero_off: assert property (
        dutyLat_q[4] == 16'h0000 |=> !ledPwm_q[4])
        else $error("zero duty output on");
    a_pwm_compare: assert property (
        ledPwm_q[6] == $past(pwmCnt_q < dutyLat_q[6]))
        else $error("compare output wrong");
    a_addr_ack: assert property (
        $rose(state_q == clpwm_pkg::ST_AACK)
        |-> $past(shift_q[7:1]) == clpwm_pkg::TARGET_ADDR && !sdaDrvN_q)
        else $error("acknowledged wrong address");
    a_reg_store: assert property (
        wrStb && ptr_q == 8'h02 |=> chanValue_q[2] == $past(shift_q) && ptr_q == 8'h03)
        else $error("write missed register or pointer");
    a_ack_hold: assert property (
        state_q == clpwm_pkg::ST_DACK |-> !sdaDrvN_q)
        else $error("data acknowledge not driven");
    a_ptr_load: assert property (
        state_q == clpwm_pkg::ST_RX && firstByte_q && sclFall
        && bitCnt_q == clpwm_pkg::BYTE_BITS && !startSeen && !stopSeen
        |=> ptr_q == $past(shift_q) && !busMode_q == !$past(busMode_q))
        else $error("pointer byte mishandled");

    c_bus_write: cover property (wrStb);
    c_read_out: cover property (state_q == clpwm_pkg::ST_MACK ##1 state_q == clpwm_pkg::ST_TX);
    c_addr_miss: cover property (state_q == clpwm_pkg::ST_ADDR ##1 state_q == clpwm_pkg::ST_IDLE);
    c_full_on: cover property (dutyLat_q[0] == cubeDuty(8'hFF));
endmodule : clpwm_top

// file: logic/clpwm_pkg.sv
// Constants and types for the eight-channel cubic LED dimmer.
// Assumes one system clock; pins reach the core through synchronisers.
package clpwm_pkg;
    // Channel count and widths
    localparam int CHANNELS = 8;
    localparam int VALUE_W = 8;
    localparam int DUTY_W = 16;
    // Timing: nominal clock and PWM rate, period in clock cycles
    localparam int unsigned CLOCK_HZ = 32768000;
    localparam int unsigned PWM_HZ = 500;
    localparam int unsigned PWM_CYCLES = CLOCK_HZ / PWM_HZ;
    // Target address and register offsets
    localparam logic [6:0] TARGET_ADDR = 7'h6C;
    localparam logic [7:0] REG_CHAN_FIRST = 8'h00;
    localparam logic [7:0] REG_CHAN_LAST = 8'h07;
    // Switch pattern step per channel
    localparam logic [7:0] SW_STEP = 8'h10;
    // Bits per serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Register reset value
    localparam logic [7:0] CHAN_RESET = 8'h00;

    // Open-drain pad drive, enable active low
    typedef struct packed {
        logic out;
        logic drvN;
    } clpwm_pad_t;

    // Serial target states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX = 7'h08,
        ST_DACK = 7'h10,
        ST_TX = 7'h20,
        ST_MACK = 7'h40
    } clpwm_state_t;
endpackage : clpwm_pkg

// file: tb/clpwm_i2c_ctrl.sv
// Bus controller model that stands on the far side of the dimmer's serial pins.
// Assumes open-drain lines with pull-ups, wired-AND in the bench top.
`timescale 1ns/1ps
module clpwm_i2c_ctrl (
    // System clock paces every bus quarter
    input wire logic sysClk,
    // Controller drives, high means released to the pull-up
    output logic sclO,
    output logic sdaO,
    // Data line level after the wired-AND
    input wire logic sdaLine
);
    // Idle bus: both lines released, clock stands still
    initial begin
        sclO = 1'b1;
        sdaO = 1'b1;
    end

    // Quarter bit of 2 system cycles, so a bit lasts 200 ns
    task automatic quarter();
        repeat (2) @(posedge sysClk);
    endtask : quarter

    // Start and repeated start: data falls while clock is high
    task automatic start();
        sdaO <= 1'b1;
        quarter();
        sclO <= 1'b1;
        quarter();
        sdaO <= 1'b0;
        quarter();
        sclO <= 1'b0;
        quarter();
    endtask : start

    // Stop: data rises while clock is high, then the bus idles
    task automatic stop();
        sdaO <= 1'b0;
        quarter();
        sclO <= 1'b1;
        quarter();
        sdaO <= 1'b1;
        quarter();
    endtask : stop

    // One bit; data held from before the rise until after the fall
    task automatic bitx(input logic b, output logic s);
        sdaO <= b;
        quarter();
        sclO <= 1'b1;
        quarter();
        // Sample off the edge so the target's register has settled
        #1 s = sdaLine;
        quarter();
        sclO <= 1'b0;
        quarter();
    endtask : bitx

    // Byte out MSB first, then the target's acknowledge (0 = taken)
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], s);
        end
        bitx(1'b1, ack);
    endtask : sendByte

    // Byte in MSB first; nack high ends a read
    task automatic recvByte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, s);
            b[i] = s;
        end
        bitx(nack, s);
    endtask : recvByte
endmodule : clpwm_i2c_ctrl

// file: tb/clpwm_top_test.sv
// Self-checking bench for the eight-channel cubic LED dimmer.
// Assumes the controller model file is compiled first; pull-ups live here.
`timescale 1ns/1ps
module clpwm_top_test;
    // Short period keeps each duty measurement to 256 cycles
    localparam int PERIOD = 256;
    localparam logic [6:0] ADDR = 7'h6C;
    logic sysClk;
    logic rst;
    logic [7:0] sw;
    logic sclO;
    logic sdaO;
    clpwm_pkg::clpwm_pad_t sclPad;
    clpwm_pkg::clpwm_pad_t sdaPad;
    logic [7:0] ledPwm;
    logic busMode;
    // Wired-AND with pull-ups: a low enable pulls the line down
    wire logic sclLine = sclO & sclPad.drvN;
    wire logic sdaLine = sdaO & sdaPad.drvN;
    int error_cnt = 0;
    int compares = 0;
    int seed = 32'h172B;
    // Reference copy of the channel registers and the lock flag
    int regs[8] = '{default: 0};
    bit locked = 1'b0;

    // 40 MHz system clock
    initial begin
        sysClk = 1'b0;
        forever #12.5 sysClk = ~sysClk;
    end

    clpwm_top #(.PWM_PERIOD(PERIOD)) i_dut (
        .sysClk(sysClk), .rst(rst), .dedicatedInputPins(sw), .sclIn(sclLine),
        .sclPad(sclPad), .sdaIn(sdaLine), .sdaPad(sdaPad), .ledPwm(ledPwm),
        .busMode(busMode));

    clpwm_i2c_ctrl i_ctrl (.sysClk(sysClk), .sclO(sclO), .sdaO(sdaO), .sdaLine(sdaLine));

    // Cubic duty, clipped to the shortened period
    function automatic int duty(input int v);
        int d;
        d = (v * v * v) >>> 8;
        return (d > PERIOD) ? PERIOD : d;
    endfunction : duty

    // Single comparison point
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Switch change; the model follows only while unlocked
    task automatic setSw(input logic [7:0] v);
        @(posedge sysClk);
        sw <= v;
        for (int n = 0; n < 8 && !locked; n++) begin
            regs[n] = (n == 0) ? v : ((v == 8'h00) ? 0 : int'(v ^ 8'(n * 16)));
        end
    endtask : setSw

    // Let two wraps pass, then count high cycles over one whole period
    task automatic measure();
        int cnt[8];
        cnt = '{default: 0};
        repeat (2 * PERIOD + 8) @(posedge sysClk);
        for (int c = 0; c < PERIOD; c++) begin
            @(negedge sysClk);
            for (int n = 0; n < 8; n++) begin
                if (ledPwm[n] === 1'b1) cnt[n]++;
            end
        end
        for (int n = 0; n < 8; n++) begin
            check("ledPwm high cycles", 32'(cnt[n]), 32'(duty(regs[n])));
        end
        check("busMode", 32'(busMode), 32'(locked));
    endtask : measure

    // Write: pointer byte then data; bytes past the last register are dropped
    task automatic xfer(input logic [6:0] a, input logic [7:0] d[$], input bit hit);
        logic ack;
        int p;
        i_ctrl.start();
        i_ctrl.sendByte({a, 1'b0}, ack);
        check("address ack", 32'(ack), 32'(!hit));
        p = d[0];
        for (int k = 0; k < d.size() && hit; k++) begin
            i_ctrl.sendByte(d[k], ack);
            check("data ack", 32'(ack), 32'h0);
            if (k > 0 && p < 8) begin
                regs[p] = d[k];
                locked = 1'b1;
            end
            if (k > 0) p++;
        end
        i_ctrl.stop();
        repeat (4) @(posedge sysClk);
        check("busMode", 32'(busMode), 32'(locked));
    endtask : xfer

    // Read n registers from ptr through a repeated start
    task automatic rd(input logic [7:0] ptr, input int n);
        logic ack;
        logic [7:0] v;
        i_ctrl.start();
        i_ctrl.sendByte({ADDR, 1'b0}, ack);
        i_ctrl.sendByte(ptr, ack);
        i_ctrl.start();
        i_ctrl.sendByte({ADDR, 1'b1}, ack);
        check("read address ack", 32'(ack), 32'h0);
        for (int k = 0; k < n; k++) begin
            i_ctrl.recvByte(k == n - 1, v);
            check("read data", 32'(v), 32'(regs[(ptr + k) % 8]));
        end
        i_ctrl.stop();
        repeat (4) @(posedge sysClk);
        // Idle bus: both pads released, output levels held low
        check("pad drive", 32'({sclPad.out, sclPad.drvN, sdaPad.out, sdaPad.drvN}), 32'h5);
    endtask : rd

    // Verdict and end of run
    task automatic complete_run();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Watchdog, about five times the expected run
    initial begin
        repeat (40000) @(posedge sysClk);
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        complete_run();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        sw = 8'h00;
        repeat (12) @(posedge sysClk);
        rst <= 1'b0;
        check("pwm period cycles", clpwm_pkg::PWM_CYCLES, 32'h10000);
        // Switch mode: zero, then random patterns
        setSw(8'h00);
        measure();
        for (int i = 0; i < 3; i++) begin
            setSw(8'($random(seed)));
            measure();
        end
        $display("switch mode test done");
        // Foreign addresses and a pointer-only write leave switch mode on
        xfer(7'h6D, '{8'h00, 8'h55}, 1'b0);
        xfer(7'h2C, '{8'h01, 8'hAA}, 1'b0);
        xfer(ADDR, '{8'h03}, 1'b1);
        setSw(8'($random(seed)) % 8'h29);
        measure();
        $display("refusal test done");
        // Write across the last register, then fill the rest
        xfer(ADDR, '{8'h06, 8'($random(seed)), 8'($random(seed)), 8'h11}, 1'b1);
        xfer(ADDR, '{8'h00, 8'($random(seed)) % 8'h29, 8'h00, 8'hFF, 8'($random(seed)) % 8'h29,
                     8'h28, 8'h01}, 1'b1);
        setSw(8'($random(seed)));
        measure();
        rd(8'h00, 8);
        $display("bus mode test done");
        // Reset in mid-run hands the registers back to the switches
        @(posedge sysClk);
        rst <= 1'b1;
        repeat (4) @(posedge sysClk);
        rst <= 1'b0;
        locked = 1'b0;
        check("busMode after reset", 32'(busMode), 32'h0);
        setSw(8'($random(seed)));
        measure();
        $display("reset test done");
        complete_run();
    end
endmodule : clpwm_top_test
